// File: hdl/mcs_seq.sv
// Operation
// - a machine cycle is six states, twelve oscillator periods
// - each state is two periods, phase 1 then phase 2, S1P1 to S6P2
// - arithmetic in phase 1, register transfers in phase 2
// - address strobe pulses S1P2-S2P1 and S4P2-S5P1
// - opcode latched into instruction register at S1P2
// - second byte of a two-byte instruction read in S4
// - one-byte instruction: S4 byte fetched, discarded, counter kept
// - instruction completes at end of S6P2 of its last cycle
// - most take one cycle; multiply and divide take four
// - two code fetches per cycle except external data move
// - external move is two cycles; second cycle skips both fetches
// - 16-bit program counter, loaded by control transfers
// - power control at 87h with baud, mode, flag, reserved bits
// - baud doubling bit doubles serial rate in modes 1, 2, 3
// - power-down needs enable set, then start ends execution
// - idle needs enable set, then start ends execution
// - modes only entered while the power-save pin permits
// - two user flags freely written and read, also on idle entry
// - interrupt ends idle, user flags kept
// - on-chip data memory kept during power-down
`timescale 1ns/1ps
module mcs_seq
	import mcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] code_data,
	output logic code_rd,
	output logic ale,
	output logic ext_data_strobe,
	input wire logic dec_two_byte,
	input wire logic [2:0] dec_cycles,
	input wire logic dec_ext_move,
	input wire logic pc_load,
	input wire logic [15:0] pc_target,
	output logic [15:0] program_counter,
	output logic [7:0] instr_reg,
	output logic [7:0] operand,
	output logic [2:0] state_num,
	output logic phase2,
	output logic alu_phase,
	output logic xfer_phase,
	output logic exec_done,
	input wire logic powersave_pin_enable,
	input wire logic irq_req,
	input wire logic [1:0] serial_mode,
	output logic baud_rate_x2,
	output logic idle_active,
	output logic powerdown_active,
	output logic ram_retain,
	output logic periph_clk_run
);
	logic [2:0] st;
	logic ph;
	logic cyc_end;
	logic run;
	mcs_mode_e mode_q;
	logic [7:0] code_s1_q, code_s2_q;
	logic pe_s1_q, pe_s2_q;
	logic [2:0] mc_q;
	logic [2:0] ncyc_q;
	logic ext_q;
	logic first_cyc, skip_cyc, last_cyc;
	logic fetch1, fetch4;
	logic [15:0] pc_q;
	logic [7:0] ir_q, opnd_q;
	logic baud_q, uf1_q, uf0_q, idle_en_q, pd_en_q;
	logic idle_wr_q, pd_wr_q, idle_arm_q, pd_arm_q;
	logic idle_go_q, pd_go_q;
	logic [7:0] rdata_q;
	logic pc_wr, idle_ok, pd_ok;

	assign run = (mode_q == MCS_RUN);

	// idle and power-down freeze the sequencer
	mcs_timing u_timing (
		.sys_clk(sys_clk),
		.srst(srst),
		.hold(!run),
		.state_q(st),
		.phase_q(ph),
		.cycle_end(cyc_end)
	);

	// code bus and pin come from outside the clock domain
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			code_s1_q <= 8'h00;
			code_s2_q <= 8'h00;
		end else begin
			code_s1_q <= code_data;
			code_s2_q <= code_s1_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pe_s1_q <= 1'b0;
			pe_s2_q <= 1'b0;
		end else begin
			pe_s1_q <= powersave_pin_enable;
			pe_s2_q <= pe_s1_q;
		end
	end

	assign first_cyc = (mc_q == 3'h0);
	// second cycle of an external move has no code fetch
	assign skip_cyc = ext_q && (mc_q == 3'h1);
	assign last_cyc = (mc_q == ncyc_q - 3'h1);
	assign fetch1 = run && (st == ST_S1) && (ph == PH_2) && !skip_cyc;
	assign fetch4 = run && (st == ST_S4) && (ph == PH_2) && !skip_cyc;
	assign exec_done = cyc_end && last_cyc;

	// cycle count taken from the decoder in S4 of the first cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ncyc_q <= CYC_ONE;
			ext_q <= 1'b0;
		end else if (run && first_cyc && st == ST_S4 && ph == PH_2) begin
			ncyc_q <= dec_ext_move ? CYC_EXT_MOVE : dec_cycles;
			ext_q <= dec_ext_move;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mc_q <= 3'h0;
		end else if (cyc_end) begin
			mc_q <= last_cyc ? 3'h0 : mc_q + 3'h1;
		end
	end

	// opcode latch closing the S1P2 fetch
	// synchroniser delay: the S1P1 byte reaches the register at the S2P1 edge
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ir_q <= 8'h00;
		end else if (run && st == ST_S2 && ph == PH_1 && first_cyc && !skip_cyc) begin
			ir_q <= code_s2_q;
		end
	end

	// second byte fetched in S4, taken one phase later
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			opnd_q <= 8'h00;
		end else if (run && st == ST_S5 && ph == PH_1 && first_cyc && dec_two_byte) begin
			opnd_q <= code_s2_q;
		end
	end

	// program counter steps on kept bytes, loads at completion
	// discarded fetches leave the counter alone
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pc_q <= PC_RESET;
		end else if (exec_done && pc_load) begin
			pc_q <= pc_target;
		end else if (fetch1 && first_cyc) begin
			pc_q <= pc_q + PC_STEP;
		end else if (fetch4 && first_cyc && dec_two_byte) begin
			pc_q <= pc_q + PC_STEP;
		end
	end

	// memory gets the strobe a phase ahead to cover the input synchroniser
	always_comb begin
		code_rd = 1'b0;
		if (run && !skip_cyc) begin
			code_rd = (st == ST_S1) || (st == ST_S4);
		end
	end

	always_comb begin
		ale = 1'b0;
		if (run) begin
			ale = ((st == ST_S1) && ph == PH_2 && !skip_cyc) ||
				((st == ST_S2) && ph == PH_1 && !skip_cyc) ||
				((st == ST_S4) && ph == PH_2) ||
				((st == ST_S5) && ph == PH_1);
		end
	end

	assign ext_data_strobe = run && skip_cyc;

	// phase 1 for arithmetic, phase 2 for transfers
	assign alu_phase = run && (ph == PH_1);
	assign xfer_phase = run && (ph == PH_2);

	assign pc_wr = reg_wr && (reg_addr == PWR_CTL_ADDR);
	// power-down start only after enable in preceding instruction
	assign pd_ok = reg_wdata[BIT_PD_START] && pd_en_q && pd_arm_q && pe_s2_q;
	// idle start only after enable in preceding instruction
	assign idle_ok = reg_wdata[BIT_IDLE_START] && idle_en_q && idle_arm_q && pe_s2_q;

	// stored bits of the power control register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			baud_q <= PWR_CTL_RESET[BIT_BAUD];
			uf1_q <= PWR_CTL_RESET[BIT_UF1];
			uf0_q <= PWR_CTL_RESET[BIT_UF0];
		end else if (pc_wr) begin
			baud_q <= reg_wdata[BIT_BAUD];
			uf1_q <= reg_wdata[BIT_UF1];
			uf0_q <= reg_wdata[BIT_UF0];
		end
	end

	// start without a fresh enable clears the enable
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			idle_en_q <= PWR_CTL_RESET[BIT_IDLE_EN];
		end else if (pc_wr && reg_wdata[BIT_IDLE_START]) begin
			idle_en_q <= 1'b0;
		end else if (pc_wr) begin
			idle_en_q <= reg_wdata[BIT_IDLE_EN];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pd_en_q <= PWR_CTL_RESET[BIT_PD_EN];
		end else if (pc_wr && reg_wdata[BIT_PD_START]) begin
			pd_en_q <= 1'b0;
		end else if (pc_wr) begin
			pd_en_q <= reg_wdata[BIT_PD_EN];
		end
	end

	// enable written in this instruction arms the start for the next one
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			idle_wr_q <= 1'b0;
			pd_wr_q <= 1'b0;
			idle_arm_q <= 1'b0;
			pd_arm_q <= 1'b0;
		end else if (exec_done) begin
			idle_wr_q <= 1'b0;
			pd_wr_q <= 1'b0;
			idle_arm_q <= idle_wr_q || (pc_wr && reg_wdata[BIT_IDLE_EN]);
			pd_arm_q <= pd_wr_q || (pc_wr && reg_wdata[BIT_PD_EN]);
		end else if (pc_wr) begin
			idle_wr_q <= idle_wr_q || reg_wdata[BIT_IDLE_EN];
			pd_wr_q <= pd_wr_q || reg_wdata[BIT_PD_EN];
		end
	end

	// a start taken mid-instruction waits for completion before the mode
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			idle_go_q <= 1'b0;
			pd_go_q <= 1'b0;
		end else if (exec_done) begin
			idle_go_q <= 1'b0;
			pd_go_q <= 1'b0;
		end else if (pc_wr) begin
			idle_go_q <= idle_go_q || idle_ok;
			pd_go_q <= pd_go_q || pd_ok;
		end
	end

	// power-down is left only by reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mode_q <= MCS_RUN;
		end else begin
			unique case (mode_q)
				MCS_RUN: begin
					if (exec_done && pd_go_q) begin
						mode_q <= MCS_PDOWN;
					end else if (exec_done && idle_go_q) begin
						mode_q <= MCS_IDLE;
					end
				end
				MCS_IDLE: begin
					if (irq_req) begin
						mode_q <= MCS_RUN;
					end
				end
				MCS_PDOWN: begin
					mode_q <= MCS_PDOWN;
				end
				default: begin
					mode_q <= MCS_RUN;
				end
			endcase
		end
	end

	// reserved bit reads zero; start bits read back the active mode
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_q <= RD_UNMAPPED;
		end else if (reg_rd && reg_addr == PWR_CTL_ADDR) begin
			rdata_q <= {baud_q, powerdown_active, idle_active, 1'b0,
				uf1_q, uf0_q, pd_en_q, idle_en_q};
		end else begin
			rdata_q <= RD_UNMAPPED;
		end
	end

	assign reg_rdata = rdata_q;
	assign program_counter = pc_q;
	assign instr_reg = ir_q;
	assign operand = opnd_q;
	assign state_num = st;
	assign phase2 = ph;
	// doubling only in serial modes 1, 2 and 3
	assign baud_rate_x2 = baud_q && (serial_mode != 2'h0);
	assign idle_active = (mode_q == MCS_IDLE);
	assign powerdown_active = (mode_q == MCS_PDOWN);
	// data memory writes blocked, contents kept
	assign ram_retain = (mode_q == MCS_PDOWN);
	assign periph_clk_run = (mode_q != MCS_PDOWN);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_cycle_twelve: assert property (
		(run && st == ST_S1 && ph == PH_1) |-> ##11 (st == ST_S6 && ph == PH_2))
		else $error("machine cycle is not twelve periods");
	a_phase_alt: assert property (
		(run && $past(run) && !$past(srst)) |-> (ph != $past(ph)))
		else $error("phase did not alternate");
	a_ale_slots: assert property (
		ale |-> ((st == ST_S1 && ph) || (st == ST_S2 && !ph) ||
		(st == ST_S4 && ph) || (st == ST_S5 && !ph)))
		else $error("address strobe outside its slots");
	a_ir_at_s1p2: assert property (
		(!$past(srst) && ir_q != $past(ir_q)) |-> $past(st == ST_S2 && ph == PH_1))
		else $error("opcode latched outside S1P2");
	a_operand_s4: assert property (
		(!$past(srst) && opnd_q != $past(opnd_q)) |-> $past(st == ST_S5 && ph == PH_1))
		else $error("second byte latched outside S4");
	a_pc_kept: assert property (
		(fetch4 && !dec_two_byte && !exec_done) |=> $stable(pc_q))
		else $error("discarded fetch moved the counter");
	a_done_s6p2: assert property (
		exec_done |-> (st == ST_S6 && ph == PH_2))
		else $error("completion outside S6P2");
	a_ext_nofetch: assert property (
		skip_cyc |-> (!code_rd && ext_data_strobe))
		else $error("code fetch during external move");
	a_mode_gated: assert property (
		(!run && $past(run) && !$past(srst)) |-> ($past(pd_go_q) || $past(idle_go_q)))
		else $error("low-power entry without valid start");
	a_bad_start: assert property (
		(pc_wr && reg_wdata[BIT_IDLE_START] && !idle_ok) |=> !idle_en_q ##0 !idle_go_q)
		else $error("unarmed idle start not refused");
	a_idle_flags: assert property (
		(idle_active && irq_req) |=> (run && $stable(uf0_q) && $stable(uf1_q)))
		else $error("idle exit lost flags");

	c_idle_entry: cover property (run ##1 idle_active);
	c_pd_entry: cover property (run ##1 powerdown_active);
	c_ext_move: cover property (skip_cyc && exec_done);
	c_muldiv: cover property (exec_done && ncyc_q == CYC_MULDIV);
endmodule : mcs_seq

// File: hdl/mcs_pkg.sv
package mcs_pkg;
	// power control register
	localparam logic [7:0] PWR_CTL_ADDR = 8'h87;
	localparam logic [7:0] PWR_CTL_RESET = 8'h00;
	localparam int BIT_BAUD = 7;
	localparam int BIT_PD_START = 6;
	localparam int BIT_IDLE_START = 5;
	localparam int BIT_RSVD = 4;
	localparam int BIT_UF1 = 3;
	localparam int BIT_UF0 = 2;
	localparam int BIT_PD_EN = 1;
	localparam int BIT_IDLE_EN = 0;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// machine cycle timing
	localparam int STATE_COUNT = 6;
	localparam int PERIODS_PER_STATE = 2;
	localparam int MC_PERIODS = STATE_COUNT * PERIODS_PER_STATE;
	localparam logic [2:0] ST_S1 = 3'h0;
	localparam logic [2:0] ST_S2 = 3'h1;
	localparam logic [2:0] ST_S3 = 3'h2;
	localparam logic [2:0] ST_S4 = 3'h3;
	localparam logic [2:0] ST_S5 = 3'h4;
	localparam logic [2:0] ST_S6 = 3'h5;
	localparam logic PH_1 = 1'b0;
	localparam logic PH_2 = 1'b1;
	// instruction lengths in machine cycles
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_EXT_MOVE = 3'h2;
	localparam logic [2:0] CYC_MULDIV = 3'h4;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] PC_STEP = 16'h0001;
	typedef enum logic [1:0] {
		MCS_RUN,
		MCS_IDLE,
		MCS_PDOWN
	} mcs_mode_e;
endpackage : mcs_pkg

// File: hdl/mcs_timing.sv
`timescale 1ns/1ps
module mcs_timing
	import mcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic hold,
	output logic [2:0] state_q,
	output logic phase_q,
	output logic cycle_end
);
	// one oscillator period per clock, so a phase is one sys_clk
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phase_q <= PH_1;
		end else if (!hold) begin
			phase_q <= ~phase_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= ST_S1;
		end else if (!hold && phase_q == PH_2) begin
			state_q <= (state_q == ST_S6) ? ST_S1 : state_q + 3'h1;
		end
	end

	assign cycle_end = (state_q == ST_S6) && (phase_q == PH_2) && !hold;

	a_state_range: assert property (@(posedge sys_clk) disable iff (srst)
		state_q <= ST_S6)
		else $error("state index out of range");
endmodule : mcs_timing

// File: tb/mcs_mem_model.sv
`timescale 1ns/1ps
module mcs_mem_model (
	input wire logic sys_clk,
	input wire logic code_rd,
	input wire logic ext_data_strobe,
	input wire logic [15:0] program_counter,
	output logic [7:0] code_data
);
	logic [7:0] last_q = 8'h00;
	always_comb begin
		if (code_rd && !ext_data_strobe) begin
			code_data = program_counter[7:0] ^ program_counter[15:8] ^ 8'h5A;
		end else begin
			// released bus must not look like the last byte
			code_data = ~last_q;
		end
	end
	always_ff @(posedge sys_clk) begin
		last_q <= code_data;
	end
endmodule : mcs_mem_model

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
	import mcs_pkg::*;
	logic sys_clk = 1'h0;
	logic srst = 1'h1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, code_data, instr_reg, operand;
	logic reg_wr = 1'h0, reg_rd = 1'h0, dec_two_byte = 1'h0, dec_ext_move = 1'h0;
	logic pc_load = 1'h0, powersave_pin_enable = 1'h1, irq_req = 1'h0;
	logic [2:0] dec_cycles = 3'h1, state_num;
	logic [15:0] pc_target = 16'h0000, program_counter, pc0;
	logic [1:0] serial_mode = 2'h0;
	logic code_rd, ale, ext_data_strobe, phase2, alu_phase, xfer_phase, exec_done, sk;
	logic baud_rate_x2, idle_active, powerdown_active, ram_retain, periph_clk_run;
	logic [3:0] s0;
	int bad_count = 0, n_compared = 0;
	always #20 sys_clk = ~sys_clk;
	mcs_seq u_mcs_seq (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.code_data, .code_rd, .ale, .ext_data_strobe, .dec_two_byte, .dec_cycles,
		.dec_ext_move, .pc_load, .pc_target, .program_counter, .instr_reg, .operand,
		.state_num, .phase2, .alu_phase, .xfer_phase, .exec_done, .powersave_pin_enable,
		.irq_req, .serial_mode, .baud_rate_x2, .idle_active, .powerdown_active, .ram_retain,
		.periph_clk_run);
	mcs_mem_model u_mcs_mem_model (.sys_clk, .code_rd, .ext_data_strobe, .program_counter,
		.code_data);
	function automatic logic [7:0] mem_byte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : mem_byte
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1;
		chk({8'h00, reg_rdata & m}, {8'h00, exp});
	endtask : rd
	// waits for an instruction end; gives up after 100 cycles
	task automatic sync;
		int i;
		@(negedge sys_clk);
		for (i = 0; i < 100 && exec_done !== 1'h1; i++) @(negedge sys_clk);
		chk({15'h0000, exec_done}, 16'h0001);
	endtask : sync
	task automatic run_instr(input logic two, input logic [2:0] cyc, input logic ext,
		input logic ld, input logic [15:0] tgt);
		int k, p;
		sync();
		@(posedge sys_clk);
		dec_two_byte <= two;
		dec_cycles <= cyc;
		dec_ext_move <= ext;
		pc_load <= ld;
		pc_target <= tgt;
		#1 pc0 = program_counter;
		for (k = 0; k < cyc; k++) begin
			for (p = 0; p < 12; p++) begin
				sk = ext && k == 1;
				@(negedge sys_clk);
				chk({6'h00, ale, code_rd, exec_done, ext_data_strobe, alu_phase, xfer_phase,
					state_num, phase2}, {6'h00, (p == 1 || p == 2) && !sk || p == 7 || p == 8,
					!sk && (p < 2 || p == 6 || p == 7), p == 11 && k == cyc - 1, sk,
					p[0] == 1'h0, p[0], p[3:1], p[0]});
			end
		end
		chk({8'h00, instr_reg}, {8'h00, mem_byte(pc0)});
		if (two) chk({8'h00, operand}, {8'h00, mem_byte(pc0 + 16'h0001)});
		if (cyc == CYC_ONE) chk(program_counter, pc0 + 16'h0001 + {15'h0000, two});
		@(posedge sys_clk);
		pc_load <= 1'h0;
		dec_two_byte <= 1'h0;
		dec_ext_move <= 1'h0;
		dec_cycles <= CYC_ONE;
		#1;
		if (ld) chk(program_counter, tgt);
	endtask : run_instr
	task automatic t_regs;
		int m;
		rd(PWR_CTL_ADDR, 8'hFF, PWR_CTL_RESET);
		wr(8'h86, 8'hFF);
		rd(8'h86, 8'hFF, RD_UNMAPPED);
		rd(PWR_CTL_ADDR, 8'hFF, 8'h00);
		wr(PWR_CTL_ADDR, 8'h9C);
		rd(PWR_CTL_ADDR, 8'hFF, 8'h8C);
		for (m = 0; m < 4; m++) begin
			@(posedge sys_clk);
			serial_mode <= m[1:0];
			@(posedge sys_clk);
			#1 chk({15'h0000, baud_rate_x2}, {15'h0000, m != 0});
		end
		wr(PWR_CTL_ADDR, 8'h00);
		#1 chk({15'h0000, baud_rate_x2}, 16'h0000);
	endtask : t_regs
	task automatic t_power;
		// start two instructions after enable is refused
		sync();
		wr(PWR_CTL_ADDR, 8'h01);
		sync();
		sync();
		wr(PWR_CTL_ADDR, 8'h21);
		sync();
		rd(PWR_CTL_ADDR, 8'h21, 8'h00);
		@(posedge sys_clk);
		powersave_pin_enable <= 1'h0;
		sync();
		wr(PWR_CTL_ADDR, 8'h01);
		sync();
		wr(PWR_CTL_ADDR, 8'h21);
		sync();
		repeat (3) @(negedge sys_clk);
		chk({15'h0000, idle_active}, 16'h0000);
		powersave_pin_enable <= 1'h1;
		wr(PWR_CTL_ADDR, 8'h00);
		sync();
		wr(PWR_CTL_ADDR, 8'h01);
		sync();
		wr(PWR_CTL_ADDR, 8'h29);
		sync();
		@(negedge sys_clk);
		chk({15'h0000, idle_active}, 16'h0001);
		s0 = {state_num, phase2};
		repeat (20) @(negedge sys_clk);
		chk({10'h000, state_num, phase2, exec_done, periph_clk_run}, {10'h000, s0, 2'h1});
		rd(PWR_CTL_ADDR, 8'h28, 8'h28);
		@(posedge sys_clk);
		irq_req <= 1'h1;
		@(posedge sys_clk);
		irq_req <= 1'h0;
		@(negedge sys_clk);
		chk({15'h0000, idle_active}, 16'h0000);
		rd(PWR_CTL_ADDR, 8'h0C, 8'h08);
		sync();
		wr(PWR_CTL_ADDR, 8'h02);
		sync();
		wr(PWR_CTL_ADDR, 8'h42);
		sync();
		@(negedge sys_clk);
		chk({13'h0000, powerdown_active, ram_retain, periph_clk_run}, 16'h0006);
		@(posedge sys_clk);
		irq_req <= 1'h1;
		@(posedge sys_clk);
		irq_req <= 1'h0;
		repeat (5) @(negedge sys_clk);
		chk({15'h0000, powerdown_active}, 16'h0001);
		@(posedge sys_clk);
		srst <= 1'h1;
		@(posedge sys_clk);
		srst <= 1'h0;
		rd(PWR_CTL_ADDR, 8'hFF, PWR_CTL_RESET);
	endtask : t_power
	initial begin
		repeat (2) @(posedge sys_clk);
		srst <= 1'h0;
		t_regs();
		run_instr(1'h0, CYC_ONE, 1'h0, 1'h0, 16'h0000);
		run_instr(1'h1, CYC_ONE, 1'h0, 1'h0, 16'h0000);
		run_instr(1'h0, CYC_MULDIV, 1'h0, 1'h0, 16'h0000);
		run_instr(1'h0, CYC_EXT_MOVE, 1'h1, 1'h0, 16'h0000);
		run_instr(1'h0, CYC_ONE, 1'h0, 1'h1, 16'h1234);
		run_instr(1'h1, CYC_ONE, 1'h0, 1'h0, 16'h0000);
		t_power();
		close_out();
	end
	// all scenarios finish well inside a thousand cycles
	initial begin
		#(40 * 4000);
		bad_count++;
		close_out();
	end
endmodule : tb
